//--- lbp_pkg.sv
// constants for the led channel blink and dimming timing block
package lbp_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] SEG_FOUR_OFFSET    = 8'h53;
    localparam logic [7:0] SEQ_PERIOD_OFFSET  = 8'h54;
    localparam logic [7:0] ON_DUTY_OFFSET     = 8'h55;
    localparam logic [7:0] ON_DURATION_OFFSET = 8'h56;
    localparam logic [7:0] BLINK_CTRL_OFFSET  = 8'h60;
    localparam logic [7:0] BLINK_STAT_OFFSET  = 8'h61;

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int          STEPS7_W        = 7;
    localparam int          STEPS5_W        = 5;
    localparam int          DUTY_W          = 5;
    localparam logic [7:0]  SEG_FOUR_MASK   = 8'h7F;
    localparam logic [7:0]  SEQ_PERIOD_MASK = 8'h7F;
    localparam logic [7:0]  ON_DUTY_MASK    = 8'h1F;
    localparam logic [7:0]  ON_DUR_MASK     = 8'h1F;
    localparam logic [7:0]  CTRL_MASK       = 8'h01;
    localparam logic [7:0]  REG_RESET       = 8'h00;
    localparam int          ENABLE_BIT      = 0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ           = 40_000_000;
    localparam int STEP_MS          = 64;
    localparam int PWM_PERIOD_US    = 8000;
    localparam int PWM_SLOTS        = 32;
    localparam int SLOT_CYCLES      = (CLK_HZ / 1_000_000) * PWM_PERIOD_US / PWM_SLOTS;
    localparam int PERIODS_PER_STEP = STEP_MS * 1000 / PWM_PERIOD_US;

    // ------------------------------------------------------------
    // blink sequence phases
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        PH_IDLE   = 2'b00,
        PH_ON     = 2'b01,
        PH_SEG4   = 2'b10,
        PH_PERIOD = 2'b11
    } lbp_phase_t;

endpackage : lbp_pkg

//--- lbp_pwm.sv
// on-signal pwm with 32 slots per period
`timescale 1ns/1ps
module lbp_pwm #(
    parameter int SLOT_CYCLES = lbp_pkg::SLOT_CYCLES
) (
    // clock and reset
    input  wire logic                      core_clk_i,
    input  wire logic                      reset_i,
    // duty
    input  wire logic [lbp_pkg::DUTY_W-1:0] duty_code_i,
    // outputs
    output logic                           channel_pwm_o,
    output logic                           period_tick_o
);

    localparam int CNT_W = (SLOT_CYCLES > 1) ? $clog2(SLOT_CYCLES) : 1;

    initial
    begin
        if (SLOT_CYCLES < 1)
            $error("lbp_pwm: SLOT_CYCLES must be at least 1");
    end

    logic [CNT_W-1:0]          cyc_cnt;
    logic [CNT_W-1:0]          next_cyc_cnt;
    logic [4:0]                slot;
    logic [4:0]                next_slot;
    logic [4:0]                duty_held;
    logic [4:0]                next_duty_held;
    logic                      next_channel_pwm;
    logic                      next_period_tick;
    logic                      slot_end;

    // ------------------------------------------------------------
    // slot divider and compare
    // ------------------------------------------------------------
    always_comb
    begin
        slot_end         = (cyc_cnt == CNT_W'(SLOT_CYCLES - 1));
        next_cyc_cnt     = slot_end ? '0 : cyc_cnt + 1'b1;
        next_slot        = slot;
        next_duty_held   = duty_held;
        next_period_tick = 1'b0;
        if (slot_end)
        begin
            next_slot = slot + 1'b1;
            if (slot == 5'h1F)
            begin
                // duty taken only at period start, no runt pulses
                next_duty_held   = duty_code_i;
                next_period_tick = 1'b1;
            end
        end
        // high for (duty + 1) of 32 slots
        next_channel_pwm = (next_slot <= next_duty_held); // R03 R04 R05
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            cyc_cnt       <= '0;
            slot          <= 5'h00;
            duty_held     <= 5'h00;
            channel_pwm_o <= 1'b0;
            period_tick_o <= 1'b0;
        end
        else
        begin
            cyc_cnt       <= next_cyc_cnt;
            slot          <= next_slot;
            duty_held     <= next_duty_held;
            channel_pwm_o <= next_channel_pwm;
            period_tick_o <= next_period_tick;
        end
    end

endmodule : lbp_pwm

//--- lbp_blink_timing.sv
// blink sequence timing and on-signal dimming for one led channel
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
// How it works
// R01: fourth segment lasts field times 64 ms
// R02: period segment lasts field times 64 ms
// R03: on-signal pwm, (duty+1)/32 of 8 ms
// R04: duty zero gives 250 us high
// R05: duty all ones keeps on-signal high
// R06: on-time lasts field times 64 ms
// R07: all four registers clear on reset
// R08: reserved bits read zero, writes ignored
module lbp_blink_timing #(
    parameter int SLOT_CYCLES = lbp_pkg::SLOT_CYCLES
) (
    // clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    // register port
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    // channel outputs
    output logic            channel_on_signal_o,
    output logic      [1:0] blink_phase_o
);

    initial
    begin
        if (lbp_pkg::PERIODS_PER_STEP < 1)
            $error("lbp_blink_timing: step shorter than pwm period");
    end

    localparam int STEP_CNT_W = (lbp_pkg::PERIODS_PER_STEP > 1) ? $clog2(lbp_pkg::PERIODS_PER_STEP) : 1;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]                segment_four_length;
    logic [7:0]                sequence_period_length;
    logic [7:0]                on_signal_duty;
    logic [7:0]                blink_on_duration;
    logic [7:0]                blink_ctrl;
    logic [7:0]                next_segment_four_length;
    logic [7:0]                next_sequence_period_length;
    logic [7:0]                next_on_signal_duty;
    logic [7:0]                next_blink_on_duration;
    logic [7:0]                next_blink_ctrl;
    logic [7:0]                next_reg_rdata;

    logic [6:0]                segment_four_steps;
    logic [6:0]                period_segment_steps;
    logic [4:0]                duty_code;
    logic [4:0]                on_duration_steps;
    logic                      enable;

    lbp_pkg::lbp_phase_t       phase;
    lbp_pkg::lbp_phase_t       next_phase;
    logic [6:0]                remain;
    logic [6:0]                next_remain;
    logic [STEP_CNT_W-1:0]     step_cnt;
    logic [STEP_CNT_W-1:0]     next_step_cnt;
    logic                      step_tick;
    logic                      channel_pwm;
    logic                      period_tick;
    logic                      next_channel_on;

    assign segment_four_steps   = segment_four_length[6:0];
    assign period_segment_steps = sequence_period_length[6:0];
    assign duty_code            = on_signal_duty[4:0];
    assign on_duration_steps    = blink_on_duration[4:0];
    assign enable               = blink_ctrl[lbp_pkg::ENABLE_BIT];

    // length in 64 ms steps of the phase being entered
    function automatic logic [6:0] phase_length(input lbp_pkg::lbp_phase_t ph,
                                                input logic [4:0] on_steps,
                                                input logic [6:0] seg4_steps,
                                                input logic [6:0] per_steps);
        logic [6:0] len;
        len = 7'h00;
        unique case (ph)
            lbp_pkg::PH_IDLE:   len = 7'h00;
            lbp_pkg::PH_ON:     len = {2'b00, on_steps};
            lbp_pkg::PH_SEG4:   len = seg4_steps;
            lbp_pkg::PH_PERIOD: len = per_steps;
        endcase
        return len;
    endfunction : phase_length

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    always_comb
    begin
        next_segment_four_length    = segment_four_length;
        next_sequence_period_length = sequence_period_length;
        next_on_signal_duty         = on_signal_duty;
        next_blink_on_duration      = blink_on_duration;
        next_blink_ctrl             = blink_ctrl;
        if (reg_wr_i)
        begin
            unique case (reg_addr_i)
                lbp_pkg::SEG_FOUR_OFFSET:    next_segment_four_length    = reg_wdata_i & lbp_pkg::SEG_FOUR_MASK; // R08
                lbp_pkg::SEQ_PERIOD_OFFSET:  next_sequence_period_length = reg_wdata_i & lbp_pkg::SEQ_PERIOD_MASK; // R08
                lbp_pkg::ON_DUTY_OFFSET:     next_on_signal_duty         = reg_wdata_i & lbp_pkg::ON_DUTY_MASK; // R08
                lbp_pkg::ON_DURATION_OFFSET: next_blink_on_duration      = reg_wdata_i & lbp_pkg::ON_DUR_MASK; // R08
                lbp_pkg::BLINK_CTRL_OFFSET:  next_blink_ctrl             = reg_wdata_i & lbp_pkg::CTRL_MASK;
                default:                     next_blink_ctrl             = blink_ctrl;
            endcase
        end
        next_reg_rdata = 8'h00;
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                lbp_pkg::SEG_FOUR_OFFSET:    next_reg_rdata = segment_four_length;
                lbp_pkg::SEQ_PERIOD_OFFSET:  next_reg_rdata = sequence_period_length;
                lbp_pkg::ON_DUTY_OFFSET:     next_reg_rdata = on_signal_duty;
                lbp_pkg::ON_DURATION_OFFSET: next_reg_rdata = blink_on_duration;
                lbp_pkg::BLINK_CTRL_OFFSET:  next_reg_rdata = blink_ctrl;
                lbp_pkg::BLINK_STAT_OFFSET:  next_reg_rdata = {5'h00, channel_on_signal_o, phase};
                default:                     next_reg_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            segment_four_length    <= lbp_pkg::REG_RESET; // R07
            sequence_period_length <= lbp_pkg::REG_RESET; // R07
            on_signal_duty         <= lbp_pkg::REG_RESET; // R07
            blink_on_duration      <= lbp_pkg::REG_RESET; // R07
            blink_ctrl             <= lbp_pkg::REG_RESET;
            reg_rdata_o            <= 8'h00;
        end
        else
        begin
            segment_four_length    <= next_segment_four_length;
            sequence_period_length <= next_sequence_period_length;
            on_signal_duty         <= next_on_signal_duty;
            blink_on_duration      <= next_blink_on_duration;
            blink_ctrl             <= next_blink_ctrl;
            reg_rdata_o            <= next_reg_rdata;
        end
    end

    // ------------------------------------------------------------
    // pwm and 64 ms step divider
    // ------------------------------------------------------------
    lbp_pwm #(
        .SLOT_CYCLES (SLOT_CYCLES)
    ) u_pwm (
        .core_clk_i    (core_clk_i),
        .reset_i       (reset_i),
        .duty_code_i   (duty_code),
        .channel_pwm_o (channel_pwm),
        .period_tick_o (period_tick)
    );

    // ------------------------------------------------------------
    // blink sequence
    // ------------------------------------------------------------
    always_comb
    begin
        step_tick     = period_tick && (step_cnt == STEP_CNT_W'(lbp_pkg::PERIODS_PER_STEP - 1));
        next_step_cnt = step_cnt;
        if (period_tick)
            next_step_cnt = step_tick ? '0 : step_cnt + 1'b1;
        next_phase  = phase;
        next_remain = remain;
        if (!enable)
        begin
            next_phase  = lbp_pkg::PH_IDLE;
            next_remain = 7'h00;
        end
        else
        begin
            unique case (phase)
                lbp_pkg::PH_IDLE:   next_phase = lbp_pkg::PH_ON;
                lbp_pkg::PH_ON:     next_phase = (remain == 7'h00) ? lbp_pkg::PH_SEG4 : phase;
                lbp_pkg::PH_SEG4:   next_phase = (remain == 7'h00) ? lbp_pkg::PH_PERIOD : phase;
                lbp_pkg::PH_PERIOD: next_phase = (remain == 7'h00) ? lbp_pkg::PH_ON : phase;
            endcase
            if (next_phase != phase)
                next_remain = phase_length(next_phase, on_duration_steps,
                                           segment_four_steps, period_segment_steps); // R01 R02 R06
            else if (step_tick)
                next_remain = remain - 1'b1; // R01 R02 R06
        end
        next_channel_on = (next_phase == lbp_pkg::PH_ON) && channel_pwm;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            phase               <= lbp_pkg::PH_IDLE;
            remain              <= 7'h00;
            step_cnt            <= '0;
            channel_on_signal_o <= 1'b0;
        end
        else
        begin
            phase               <= next_phase;
            remain              <= next_remain;
            step_cnt            <= next_step_cnt;
            channel_on_signal_o <= next_channel_on;
        end
    end

    assign blink_phase_o = phase;

endmodule : lbp_blink_timing

//--- lbp_blink_timing_asserts.sv
// port assertions for the blink timing block
`timescale 1ns/1ps
module lbp_blink_timing_chk #(
    parameter int SLOT_CYCLES = lbp_pkg::SLOT_CYCLES
) (
    // clock and reset
    input wire logic       core_clk_i,
    input wire logic       reset_i,
    // watched ports
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       channel_on_signal_o,
    input wire logic [1:0] blink_phase_o
);
    // ------------------------------------------------------------
    // duty shadow and full-on counter
    // ------------------------------------------------------------
    localparam int FULL_WAIT = 2 * 32 * SLOT_CYCLES + 2;
    logic [4:0]  duty;
    logic [15:0] full_cnt;
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i) duty <= 5'h00;
        else if (reg_wr_i && reg_addr_i == lbp_pkg::ON_DUTY_OFFSET) duty <= reg_wdata_i[4:0];
        if (reset_i || duty != 5'h1F || blink_phase_o != lbp_pkg::PH_ON) full_cnt <= 16'h0000;
        else if (full_cnt != 16'hFFFF) full_cnt <= full_cnt + 16'h0001;
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    a_rdata_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    a_reset_clear: assert property ($fell(reset_i) |-> reg_rdata_o == 8'h00 && blink_phase_o == 2'h0 && !channel_on_signal_o)
        else $error("outputs not cleared after reset");
    a_seg_mask: assert property (reg_rd_i && reg_addr_i inside {8'h53, 8'h54} |=> !reg_rdata_o[7])
        else $error("segment register top bit not zero");
    a_duty_mask: assert property (reg_rd_i && reg_addr_i inside {8'h55, 8'h56} |=> reg_rdata_o[7:5] == 3'h0)
        else $error("five-bit register top bits not zero");
    a_unmapped_zero: assert property (reg_rd_i && !(reg_addr_i inside {[8'h53:8'h56], 8'h60, 8'h61}) |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_full_duty_high: assert property (full_cnt >= FULL_WAIT && $past(blink_phase_o) == 2'h1 && blink_phase_o == 2'h1 |-> channel_on_signal_o)
        else $error("full duty on-signal went low");
    a_dark_off_phase: assert property (blink_phase_o != 2'h1 && $past(blink_phase_o) != 2'h1 |-> !channel_on_signal_o)
        else $error("on-signal high outside on phase");
    a_enter_on: assert property (reg_wr_i && reg_addr_i == 8'h60 && reg_wdata_i[0] && blink_phase_o == 2'h0 ##1 !reg_wr_i |=> blink_phase_o == 2'h1)
        else $error("enable did not start on phase");
    a_phase_order: assert property (blink_phase_o != $past(blink_phase_o) && blink_phase_o != 2'h0 |-> blink_phase_o == (($past(blink_phase_o) == 2'h3) ? 2'h1 : $past(blink_phase_o) + 2'h1))
        else $error("phase order broken");
    c_seg_to_period: cover property ($past(blink_phase_o) == 2'h2 && blink_phase_o == 2'h3);
    c_full_on: cover property (full_cnt >= FULL_WAIT);
    c_period_to_on: cover property ($past(blink_phase_o) == 2'h3 && blink_phase_o == 2'h1);
endmodule : lbp_blink_timing_chk
bind lbp_blink_timing lbp_blink_timing_chk #(.SLOT_CYCLES(SLOT_CYCLES)) u_chk (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .channel_on_signal_o(channel_on_signal_o), .blink_phase_o(blink_phase_o));

//--- lbp_led_sink.sv
// led current sink model counting lit cycles
`timescale 1ns/1ps
module lbp_led_sink (
    // clock and drive
    input  wire logic        core_clk_i,
    input  wire logic        sink_on_i,
    input  wire logic        measure_i,
    // observation
    output logic      [31:0] lit_cycles_o
);
    // ------------------------------------------------------------
    // lit cycle counter, cleared outside a window
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (!measure_i) lit_cycles_o <= 32'h0000_0000;
        else if (sink_on_i) lit_cycles_o <= lit_cycles_o + 32'h0000_0001;
    end
endmodule : lbp_led_sink

//--- tb_lbp_blink_timing.sv
// testbench for the blink timing block
`timescale 1ns/1ps
module tb_lbp_blink_timing;
    // ------------------------------------------------------------
    // stimulus, model and checks
    // ------------------------------------------------------------
    localparam int SC   = 4;
    localparam int PER  = SC * lbp_pkg::PWM_SLOTS;
    localparam int STEP = PER * lbp_pkg::PERIODS_PER_STEP;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        meas = 1'b0;
    logic [7:0]  rdata;
    logic        on;
    logic [1:0]  phase;
    logic [31:0] lit;
    integer      seed = 32'he24491e8;
    int          n_fail = 0;
    int          n_tests = 0;
    lbp_blink_timing #(.SLOT_CYCLES(SC)) u_lbp_blink_timing (.core_clk_i(clk), .reset_i(rst), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .channel_on_signal_o(on),
        .blink_phase_o(phase));
    lbp_led_sink u_lbp_led_sink (.core_clk_i(clk), .sink_on_i(on), .measure_i(meas), .lit_cycles_o(lit));
    initial forever #12.5 clk = ~clk;
    task automatic conclude();
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin n_fail++; $display("MISMATCH %s expected %h seen %h", nm, e, g); end
    endtask : chk_reg
    task automatic chk_len(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin n_fail++; $display("MISMATCH %s expected %0d seen %0d", nm, e, g); end
    endtask : chk_len
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic run_len(input logic [1:0] p, input int lim, output int n);
        n = 0;
        while (phase === p && n < lim) begin @(posedge clk); #1; n++; end
        if (n == lim) begin n_fail++; conclude(); end
    endtask : run_len
    function automatic logic [7:0] mask_of(input logic [7:0] a);
        case (a)
            8'h53, 8'h54: return 8'h7F;
            8'h55, 8'h56: return 8'h1F;
            8'h60: return 8'h01;
            default: return 8'h00;
        endcase
    endfunction : mask_of
    function automatic logic [31:0] span_ok(input int s, input int n);
        if (s == 0) return n == 1;
        // free-running step ticks: first tick lands 1..STEP cycles in, exit one cycle after the last
        return n > (s - 1) * STEP + 1 && n <= s * STEP + 1;
    endfunction : span_ok
    initial
    begin
        logic [7:0] a, d, g;
        logic [7:0] regs [5] = '{8'h53, 8'h54, 8'h55, 8'h56, 8'h60};
        int n, st [3];
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        foreach (regs[i]) begin rd_reg(regs[i], g); chk_reg("reset value", 8'h00, g); end
        foreach (regs[i])
            for (int k = 0; k < 3; k++)
            begin
                d = (k == 0) ? 8'hFF : $random(seed);
                wr_reg(regs[i], d);
                rd_reg(regs[i], g);
                chk_reg("register readback", d & mask_of(regs[i]), g);
            end
        for (int k = 0; k < 4; k++)
        begin
            do a = $random(seed); while (mask_of(a) != 8'h00 || a == 8'h61);
            wr_reg(a, 8'hFF);
            rd_reg(a, g);
            chk_reg("unmapped read", 8'h00, g);
        end
        $display("test registers done");
        for (int k = 0; k < 4; k++)
        begin
            foreach (st[j]) st[j] = (k == 0) ? 0 : 1 + ($random(seed) & 1);
            wr_reg(8'h60, 8'h00);
            wr_reg(8'h56, st[0]);
            wr_reg(8'h53, st[1]);
            wr_reg(8'h54, st[2]);
            wr_reg(8'h60, 8'h01);
            run_len(2'h0, 40, n);
            run_len(2'h1, 200000, n);
            chk_len("on phase span", 1, span_ok(st[0], n));
            chk_reg("phase after on", 8'h02, {6'h00, phase});
            run_len(2'h2, 200000, n);
            chk_len("segment four span", 1, span_ok(st[1], n));
            chk_reg("phase after segment", 8'h03, {6'h00, phase});
            run_len(2'h3, 200000, n);
            chk_len("period span", 1, span_ok(st[2], n));
            chk_reg("phase after period", 8'h01, {6'h00, phase});
        end
        $display("test sequence done");
        wr_reg(8'h60, 8'h00);
        wr_reg(8'h56, 8'h1F);
        wr_reg(8'h60, 8'h01);
        for (int k = 0; k < 6; k++)
        begin
            d = (k == 0) ? 8'h00 : (k == 1) ? 8'h1F : $random(seed) & 8'h1F;
            wr_reg(8'h55, d);
            repeat (2 * PER) @(posedge clk);
            meas <= 1'b1;
            repeat (PER) @(posedge clk);
            meas <= 1'b0;
            #1 chk_len("lit cycles per period", (d + 1) * SC, lit);
        end
        $display("test duty done");
        conclude();
    end
endmodule : tb_lbp_blink_timing
